/* File: rtl/adc_ctrl_defines.svh */
// register map, field positions, codes and timing counts of the converter control
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ADC_OFF_CTRL        12'h000
`define ADC_OFF_SELECT      12'h004
`define ADC_OFF_RESULT_LOW  12'h008
`define ADC_OFF_RESULT_HIGH 12'h00C

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define ADC_CTRL_ENABLE_BIT 7
`define ADC_CTRL_START_BIT  6
`define ADC_CTRL_DONE_BIT   4
`define ADC_CTRL_IE_BIT     3

// ----------------------------------------------------------------------------
// select register fields
// ----------------------------------------------------------------------------
`define ADC_SEL_REF_HI      7
`define ADC_SEL_REF_LO      6
`define ADC_SEL_LEFT_BIT    5
`define ADC_SEL_CHAN_HI     4

// ----------------------------------------------------------------------------
// reference codes
// ----------------------------------------------------------------------------
`define ADC_REF_EXTERNAL    2'h0
`define ADC_REF_SUPPLY      2'h1
`define ADC_REF_INT_1V1     2'h2
`define ADC_REF_INT_2V56    2'h3

// ----------------------------------------------------------------------------
// channel codes and limits
// ----------------------------------------------------------------------------
`define ADC_CHAN_DIFF_FIRST 5'h08
`define ADC_CHAN_DIFF_LAST  5'h1D
`define ADC_SE_MAX          13'sh03FF
`define ADC_SE_MIN          13'sh0000
`define ADC_DIFF_MAX        13'sh01FF
`define ADC_DIFF_MIN        -13'sh0200

// ----------------------------------------------------------------------------
// sleep mode codes
// ----------------------------------------------------------------------------
`define ADC_SLEEP_IDLE      3'h0
`define ADC_SLEEP_NOISE_RED 3'h1

// ----------------------------------------------------------------------------
// conversion lengths in converter clocks
// ----------------------------------------------------------------------------
`define ADC_CONV_NORMAL     5'd13
`define ADC_CONV_FIRST      5'd25

`endif

/* File: rtl/adc_ctrl_pkg.sv */
// types shared by the converter control design
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    SLEEP_AWAKE,
    SLEEP_ARMED,
    SLEEP_CONVERTING
  } sleep_state_t;

endpackage

/* File: rtl/result_formatter.sv */
// packs a 10-bit conversion code into the two result bytes, left or right adjusted
module result_formatter (
  input  wire logic [9:0] code,
  input  wire logic       left_adjust_select,
  output logic      [7:0] result_low_byte,
  output logic      [7:0] result_high_byte
);

  always_comb begin
    if (left_adjust_select) begin
      result_high_byte = code[9:2];
      result_low_byte  = {code[1:0], 6'h00};
    end else begin
      result_low_byte  = code[7:0];
      result_high_byte = {6'h00, code[9:8]};
    end
  end

endmodule

/* File: rtl/adc_result_and_sleep_control.sv */
// converter control: registers, conversion sequencing, sleep noise canceler, result packing
// Notes on behaviour
// R01 - single-ended inputs above reference clamp at full scale, never wrap
// R02 - reference can be analog supply, internal bandgap-derived, or external pin
// R03 - software should discard first result after a reference change
// R04 - software enables converter idle, single mode, completion interrupt before sleeping
// R05 - idle or low-noise sleep starts a conversion once processor halts
// R06 - sleep-started conversion completion wakes processor for completion handler
// R07 - other wake-up leaves conversion running; completion request still raised
// R08 - processor stays awake until another sleep instruction
// R09 - other sleep modes leave converter power to its enable bit
// R10 - software should clear enable before deeper sleep
// R11 - software should toggle enable after such sleep before differential work
// R12 - shared port pins must not toggle during a conversion
// R13 - same input on both differential sides measures residual offset
// R14 - result bytes hold the result once done flag is set
// R15 - single-ended code is unsigned, zero to full scale minus one step
// R16 - differential code is two's complement, saturating at 0x200 and 0x1FF
// R17 - top result bit in high byte is the sign of differential results
// R18 - zero difference gives zero, slightly negative gives all ones
// R19 - left adjust picks which bits land in high and low bytes
// R20 - reference field: 00 external, 01 supply, 10 1.1V, 11 2.56V
// R21 - left adjust changes result presentation immediately
// R22 - start bit reads one while busy; writing zero does nothing
// R23 - both result bytes update together at completion
`include "adc_ctrl_defines.svh"

module adc_result_and_sleep_control #(
  parameter int PRESCALE = 2
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sleep_enter,
  input  wire logic [2:0]        sleep_mode,
  input  wire logic              cpu_halted,
  input  wire logic              other_wake,
  input  wire logic signed [12:0] analog_level,
  output logic                   cpu_wake,
  output logic                   conversion_irq,
  output logic                   converter_power,
  output logic                   conversion_busy,
  output logic      [1:0]        reference_select_out,
  output logic      [4:0]        channel_select_out
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  logic       converter_enable;
  logic       conversion_ie;
  logic       conversion_done_flag;
  logic [1:0] reference_select_field;
  logic       left_adjust_select;
  logic [4:0] channel_field;
  logic [9:0] result_code;
  logic       first_pending;
  logic [4:0] adc_tick_count;
  logic [7:0] prescale_count;
  logic       adc_tick;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;
  adc_ctrl_pkg::sleep_state_t sleep_state;
  default clocking sys_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  function automatic logic is_differential(input logic [4:0] chan);
    is_differential = (chan >= `ADC_CHAN_DIFF_FIRST) && (chan <= `ADC_CHAN_DIFF_LAST);
  endfunction

  function automatic logic [9:0] saturate(input logic signed [12:0] level, input logic diff);
    logic signed [12:0] upper;
    logic signed [12:0] lower;
    upper = diff ? `ADC_DIFF_MAX : `ADC_SE_MAX;
    lower = diff ? `ADC_DIFF_MIN : `ADC_SE_MIN;
    saturate = (level > upper) ? upper[9:0] : ((level < lower) ? lower[9:0] : level[9:0]);
  endfunction

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic access_done;
  logic wr_ctrl;
  logic wr_select;
  logic sw_start;
  logic sleep_start;
  logic conv_complete;
  logic [4:0] conv_length;

  assign access_done = psel && penable && pready;
  assign wr_ctrl     = access_done && pwrite && (paddr == `ADC_OFF_CTRL);
  assign wr_select   = access_done && pwrite && (paddr == `ADC_OFF_SELECT);
  // writing zero to start is ignored; a start while busy changes nothing
  assign sw_start    = wr_ctrl && pwdata[`ADC_CTRL_START_BIT] && pwdata[`ADC_CTRL_ENABLE_BIT]
                       && !conversion_busy; // R22
  assign sleep_start = (sleep_state == adc_ctrl_pkg::SLEEP_ARMED) && cpu_halted
                       && converter_enable && !conversion_busy; // R05
  assign conv_length = first_pending ? `ADC_CONV_FIRST : `ADC_CONV_NORMAL;
  assign conv_complete = conversion_busy && adc_tick && (adc_tick_count == conv_length - 5'd1);
  assign adc_tick    = (prescale_count == 8'(PRESCALE - 1));

  // --------------------------------------------------------------------------
  // apb slave: one wait state, registered answer
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == `ADC_OFF_CTRL) begin
          prdata[`ADC_CTRL_ENABLE_BIT] <= converter_enable;
          prdata[`ADC_CTRL_START_BIT]  <= conversion_busy; // R22
          prdata[`ADC_CTRL_DONE_BIT]   <= conversion_done_flag;
          prdata[`ADC_CTRL_IE_BIT]     <= conversion_ie;
        end else if (paddr == `ADC_OFF_SELECT) begin
          prdata[7:0] <= {reference_select_field, left_adjust_select, channel_field};
        end else if (paddr == `ADC_OFF_RESULT_LOW) begin
          prdata[7:0] <= result_low_byte; // R14 R21
        end else if (paddr == `ADC_OFF_RESULT_HIGH) begin
          prdata[7:0] <= result_high_byte; // R14 R17 R21
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
  property p_start_reads_busy;
    (psel && penable && !pready && paddr == `ADC_OFF_CTRL)
      |=> prdata[`ADC_CTRL_START_BIT] == $past(conversion_busy);
  endproperty
  a_start_reads_busy: assert property (p_start_reads_busy) else $error("busy misread"); // R22

  // --------------------------------------------------------------------------
  // control and select registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      converter_enable       <= 1'b0;
      conversion_ie          <= 1'b0;
      reference_select_field <= `ADC_REF_EXTERNAL;
      left_adjust_select     <= 1'b0;
      channel_field          <= 5'h00;
    end else begin
      // sleep entry never touches the enable: only software does
      if (wr_ctrl) begin
        converter_enable <= pwdata[`ADC_CTRL_ENABLE_BIT]; // R09
        conversion_ie    <= pwdata[`ADC_CTRL_IE_BIT];
      end
      if (wr_select) begin
        reference_select_field <= pwdata[`ADC_SEL_REF_HI:`ADC_SEL_REF_LO]; // R20
        left_adjust_select     <= pwdata[`ADC_SEL_LEFT_BIT];
        channel_field          <= pwdata[`ADC_SEL_CHAN_HI:0];
      end
    end
  end
  property p_enable_kept;
    (sleep_enter && !wr_ctrl) |=> converter_enable == $past(converter_enable);
  endproperty
  a_enable_kept: assert property (p_enable_kept) else $error("sleep changed enable"); // R09

  // done flag: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_complete) begin
      conversion_done_flag <= 1'b1; // R06 R07 R14
    end else if (wr_ctrl && pwdata[`ADC_CTRL_DONE_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end
  property p_done_clears_busy;
    conv_complete |=> !conversion_busy && conversion_done_flag;
  endproperty
  a_done_clears_busy: assert property (p_done_clears_busy) else $error("not flagged"); // R14

  // --------------------------------------------------------------------------
  // conversion sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prescale_count <= 8'h00;
    end else if (adc_tick || !converter_enable) begin
      prescale_count <= 8'h00;
    end else begin
      prescale_count <= prescale_count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      first_pending <= 1'b0;
    end else if (wr_ctrl && pwdata[`ADC_CTRL_ENABLE_BIT] && !converter_enable) begin
      first_pending <= 1'b1;
    end else if (conv_complete) begin
      first_pending <= 1'b0;
    end
  end

  // disabling aborts; another wake-up does not, so the conversion runs on
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      conversion_busy <= 1'b0;
      adc_tick_count  <= 5'd0;
    end else if (wr_ctrl && !pwdata[`ADC_CTRL_ENABLE_BIT]) begin
      conversion_busy <= 1'b0;
      adc_tick_count  <= 5'd0;
    end else if (sw_start || sleep_start) begin
      conversion_busy <= 1'b1; // R05
      adc_tick_count  <= 5'd0;
    end else if (conv_complete) begin
      conversion_busy <= 1'b0; // R07 R22
    end else if (conversion_busy && adc_tick) begin
      adc_tick_count  <= adc_tick_count + 5'd1;
    end
  end

  // reference and channel held steady while converting
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reference_select_out <= `ADC_REF_EXTERNAL;
      channel_select_out   <= 5'h00;
    end else if (!conversion_busy) begin
      reference_select_out <= reference_select_field; // R02 R20
      channel_select_out   <= channel_field; // R13
    end
  end

  // single capture keeps both bytes from one conversion
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      result_code <= 10'h000;
    end else if (conv_complete) begin
      result_code <= saturate(analog_level, is_differential(channel_select_out)); // R01 R15 R16 R18 R23
    end
  end
  property p_se_saturate;
    (conv_complete && !is_differential(channel_select_out) && analog_level > `ADC_SE_MAX)
      |=> result_code == 10'h3FF;
  endproperty
  a_se_saturate: assert property (p_se_saturate) else $error("no full-scale clamp"); // R01
  property p_diff_saturate;
    (conv_complete && is_differential(channel_select_out) && analog_level < `ADC_DIFF_MIN)
      |=> result_code == 10'h200;
  endproperty
  a_diff_saturate: assert property (p_diff_saturate) else $error("no negative clamp"); // R16

  result_formatter u_result_formatter (
    .code               (result_code),
    .left_adjust_select (left_adjust_select),
    .result_low_byte    (result_low_byte),
    .result_high_byte   (result_high_byte)
  ); // R19
  property p_left_format;
    left_adjust_select |-> result_high_byte == result_code[9:2] && result_low_byte[5:0] == 6'h00;
  endproperty
  a_left_format: assert property (p_left_format) else $error("left adjust misplaced"); // R19

  // --------------------------------------------------------------------------
  // sleep noise canceler
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sleep_state <= adc_ctrl_pkg::SLEEP_AWAKE;
      cpu_wake    <= 1'b0;
    end else begin
      cpu_wake <= 1'b0;
      case (sleep_state)
        adc_ctrl_pkg::SLEEP_AWAKE: begin
          if (sleep_enter && converter_enable && !conversion_busy &&
              (sleep_mode == `ADC_SLEEP_IDLE || sleep_mode == `ADC_SLEEP_NOISE_RED)) begin
            sleep_state <= adc_ctrl_pkg::SLEEP_ARMED; // R05 R09
          end
        end
        adc_ctrl_pkg::SLEEP_ARMED: begin
          if (other_wake || !converter_enable) begin
            sleep_state <= adc_ctrl_pkg::SLEEP_AWAKE;
          end else if (sleep_start) begin
            sleep_state <= adc_ctrl_pkg::SLEEP_CONVERTING;
          end
        end
        adc_ctrl_pkg::SLEEP_CONVERTING: begin
          if (other_wake || !conversion_busy) begin
            sleep_state <= adc_ctrl_pkg::SLEEP_AWAKE; // R07 R08
          end else if (conv_complete) begin
            sleep_state <= adc_ctrl_pkg::SLEEP_AWAKE; // R08
            cpu_wake    <= conversion_ie; // R06
          end
        end
        default: sleep_state <= adc_ctrl_pkg::SLEEP_AWAKE;
      endcase
    end
  end
  property p_sleep_starts;
    (sleep_start && !wr_ctrl) |=> conversion_busy;
  endproperty
  a_sleep_starts: assert property (p_sleep_starts) else $error("no sleep start"); // R05
  property p_wake_on_done;
    (sleep_state == adc_ctrl_pkg::SLEEP_CONVERTING && conv_complete && !other_wake
     && conversion_ie) |=> cpu_wake && conversion_done_flag;
  endproperty
  a_wake_on_done: assert property (p_wake_on_done) else $error("no wake on done"); // R06
  property p_other_wake_keeps_conv;
    (sleep_state == adc_ctrl_pkg::SLEEP_CONVERTING && other_wake && conversion_busy
     && !conv_complete && !wr_ctrl) |=> conversion_busy;
  endproperty
  a_other_wake_keeps_conv: assert property (p_other_wake_keeps_conv) // R07
    else $error("other wake-up aborted the conversion");
  property p_stay_awake;
    (sleep_state == adc_ctrl_pkg::SLEEP_AWAKE && !sleep_enter)
      |=> sleep_state == adc_ctrl_pkg::SLEEP_AWAKE;
  endproperty
  a_stay_awake: assert property (p_stay_awake) else $error("left awake unasked"); // R08

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      conversion_irq  <= 1'b0;
      converter_power <= 1'b0;
    end else begin
      conversion_irq  <= conversion_done_flag && conversion_ie; // R07
      converter_power <= converter_enable; // R09
    end
  end

endmodule

/* File: test/tb_adc_result_and_sleep_control.sv */
// self-checking bench for the converter control block
`include "adc_ctrl_defines.svh"

module tb_adc_result_and_sleep_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic               sys_clk = 0;
  logic               reset_n = 0;
  logic               psel = 0;
  logic               penable = 0;
  logic               pwrite = 0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               sleep_enter = 0;
  logic [2:0]         sleep_mode = 3'h0;
  logic               cpu_halted = 0;
  logic               other_wake = 0;
  logic signed [12:0] analog_level = 13'sh0000;
  logic               cpu_wake;
  logic               conversion_irq;
  logic               converter_power;
  logic               conversion_busy;
  logic [1:0]         reference_select_out;
  logic [4:0]         channel_select_out;
  logic [9:0]         prev_code = 10'h000;
  int                 miscompares = 0;
  int                 tests_run = 0;

  always #10 sys_clk = ~sys_clk;

  // prescale 4 keeps a conversion longer than the few bus cycles issued during it
  adc_result_and_sleep_control #(.PRESCALE(4)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_enter(sleep_enter), .sleep_mode(sleep_mode), .cpu_halted(cpu_halted),
    .other_wake(other_wake), .analog_level(analog_level), .cpu_wake(cpu_wake),
    .conversion_irq(conversion_irq), .converter_power(converter_power),
    .conversion_busy(conversion_busy), .reference_select_out(reference_select_out),
    .channel_select_out(channel_select_out)
  );

  // ---------------------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // outputs read right after an edge still show the value sampled at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (conversion_busy !== 1'b0 && n < 300);
  endtask

  task automatic pulse_sleep(input logic [2:0] mode);
    sleep_enter <= 1; sleep_mode <= mode;
    @(posedge sys_clk);
    sleep_enter <= 0; cpu_halted <= 1;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_and_map;
    logic [31:0] r;
    logic        e;
    rd_chk(`ADC_OFF_CTRL, 32'h0, "ctrl reset");
    rd_chk(`ADC_OFF_SELECT, 32'h0, "select reset");
    rd_chk(`ADC_OFF_RESULT_HIGH, 32'h0, "high reset");
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
  endtask

  task automatic t_refs;
    logic [1:0] codes [4];
    codes = '{`ADC_REF_EXTERNAL, `ADC_REF_SUPPLY, `ADC_REF_INT_1V1, `ADC_REF_INT_2V56};
    for (int i = 0; i < 4; i++) begin
      wr(`ADC_OFF_SELECT, {24'h0, codes[i], 6'h00});
      cycles(2);
      chk({30'h0, reference_select_out}, i, "reference out");
    end
    wr(`ADC_OFF_SELECT, 32'h0);
  endtask

  task automatic conv(input logic [4:0] ch, input logic signed [12:0] lvl,
                      input logic [9:0] code);
    analog_level <= lvl;
    wr(`ADC_OFF_SELECT, {24'h0, 3'b000, ch});
    wr(`ADC_OFF_CTRL, 32'h0000_00D0);
    wr(`ADC_OFF_CTRL, 32'h0000_0080);
    rd_chk(`ADC_OFF_CTRL, 32'h0000_00C0, "busy bit");
    wr(`ADC_OFF_SELECT, {24'h0, 3'b001, ch});
    rd_chk(`ADC_OFF_RESULT_HIGH, {24'h0, prev_code[9:2]}, "live left");
    wait_idle();
    chk({27'h0, channel_select_out}, {27'h0, ch}, "channel out");
    rd_chk(`ADC_OFF_CTRL, 32'h0000_0090, "done flag");
    rd_chk(`ADC_OFF_RESULT_HIGH, {24'h0, code[9:2]}, "left high");
    rd_chk(`ADC_OFF_RESULT_LOW, {24'h0, code[1:0], 6'h00}, "left low");
    wr(`ADC_OFF_SELECT, {24'h0, 3'b000, ch});
    rd_chk(`ADC_OFF_RESULT_LOW, {24'h0, code[7:0]}, "right low");
    rd_chk(`ADC_OFF_RESULT_HIGH, {30'h0, code[9:8]}, "right high");
    prev_code = code;
  endtask

  task automatic t_sleep_wake(input logic [2:0] mode);
    int n;
    int busy_seen;
    int woke;
    n = 0; busy_seen = 0; woke = 0;
    wr(`ADC_OFF_CTRL, 32'h0000_0098);
    pulse_sleep(mode);
    while (woke == 0 && n < 400) begin
      @(posedge sys_clk);
      n++;
      if (conversion_busy === 1'b1) busy_seen++;
      if (cpu_wake === 1'b1) woke++;
    end
    chk(busy_seen > 0, 1, "sleep start");
    chk(woke, 1, "wake on done");
    busy_seen = 0;
    for (int i = 0; i < 80; i++) begin
      @(posedge sys_clk);
      if (conversion_busy !== 1'b0) busy_seen++;
    end
    chk(busy_seen, 0, "no restart without sleep");
    cpu_halted <= 0;
    rd_chk(`ADC_OFF_CTRL, 32'h0000_0098, "flag after sleep");
  endtask

  task automatic t_other_wake;
    int n;
    int woke;
    n = 0; woke = 0;
    wr(`ADC_OFF_CTRL, 32'h0000_0098);
    pulse_sleep(`ADC_SLEEP_NOISE_RED);
    while (conversion_busy !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, conversion_busy}, 32'h1, "busy before other wake");
    other_wake <= 1; cpu_halted <= 0;
    @(posedge sys_clk);
    other_wake <= 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      if (cpu_wake === 1'b1) woke++;
    end
    chk(woke, 0, "no wake pulse");
    chk({31'h0, conversion_irq}, 32'h1, "irq still raised");
  endtask

  task automatic t_other_modes;
    int busy_seen;
    busy_seen = 0;
    wr(`ADC_OFF_CTRL, 32'h0000_0090);
    pulse_sleep(3'h4);
    for (int i = 0; i < 80; i++) begin
      @(posedge sys_clk);
      if (conversion_busy !== 1'b0) busy_seen++;
    end
    cpu_halted <= 0;
    chk(busy_seen, 0, "no conversion in deep sleep");
    chk({31'h0, converter_power}, 32'h1, "power kept");
    wr(`ADC_OFF_CTRL, 32'h0000_0000);
    cycles(2);
    chk({31'h0, converter_power}, 32'h0, "power off");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    cycles(6);
    reset_n <= 1;
    t_reset_and_map();
    t_refs();
    conv(5'h00, 13'sd2000, 10'h3FF);
    conv(5'h00, -13'sd5, 10'h000);
    conv(5'h00, 13'sd700, 10'h2BC);
    conv(5'h08, 13'sd0, 10'h000);
    conv(5'h08, -13'sd1, 10'h3FF);
    conv(5'h0D, -13'sd400, 10'h270);
    conv(5'h10, 13'sd600, 10'h1FF);
    conv(5'h10, -13'sd600, 10'h200);
    t_sleep_wake(`ADC_SLEEP_NOISE_RED);
    t_sleep_wake(`ADC_SLEEP_IDLE);
    t_other_wake();
    t_other_modes();
    close_out();
  end

  // every scenario together stays well under this span
  initial begin
    cycles(30000);
    miscompares++;
    close_out();
  end
endmodule
